// *** core/bkr_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none

module bkr_ctrl #(
  parameter int         SS_CYCLES    = bkr_pkg::SS_CYC,
  parameter int         RETRY_CYCLES = bkr_pkg::RETRY_CYC,
  parameter logic [3:0] VIN_OV_HIGH  = 4'h0
) (
  // Clock and reset
  input  wire logic                                 mclk_i,
  input  wire logic                                 rst_b_i,
  // Register port from the serial interface
  input  wire logic                                 reg_wr_i,
  input  wire logic                                 reg_rd_i,
  input  wire logic [7:0]                           reg_addr_i,
  input  wire logic [7:0]                           reg_wdata_i,
  output var  logic [7:0]                           reg_rdata_o,
  // System state
  input  wire logic [bkr_pkg::NREG-1:0]             seq_enable_i,
  input  wire logic                                 sleep_i,
  input  wire logic                                 deep_sleep_mode_i,
  input  wire logic [bkr_pkg::NREG-1:0]             power_ok_status_i,
  // Power stage sense
  input  wire logic [bkr_pkg::NREG-1:0]             cycle_start_i,
  input  wire logic [bkr_pkg::NREG-1:0]             hs_request_i,
  input  wire logic [bkr_pkg::NREG-1:0]             peak_warn_i,
  input  wire logic [bkr_pkg::NREG-1:0]             peak_limit_i,
  input  wire logic [bkr_pkg::NREG-1:0]             peak_short_i,
  input  wire logic [bkr_pkg::NREG-1:0]             valley_limit_i,
  // Power stage control
  output var  logic [bkr_pkg::NREG-1:0][15:0]       target_mv_o,
  output var  logic [bkr_pkg::NREG-1:0][7:0]        active_code_o,
  output var  logic [bkr_pkg::NREG-1:0]             range_low_o,
  output var  logic [bkr_pkg::NREG-1:0]             run_o,
  output var  logic [bkr_pkg::NREG-1:0]             soft_start_o,
  output var  logic [bkr_pkg::NREG-1:0]             discharge_o,
  output var  logic [bkr_pkg::NREG-1:0]             force_pwm_o,
  output var  logic [bkr_pkg::NREG-1:0]             power_save_allow_o,
  output var  logic [bkr_pkg::NREG-1:0]             light_load_power_mode_o,
  output var  logic [bkr_pkg::NREG-1:0]             ovuv_ignore_o,
  output var  logic [bkr_pkg::NREG-1:0]             hs_gate_o,
  output var  logic [bkr_pkg::NREG-1:0][3:0]        current_limit_code_peak_amp_o,
  output var  logic [bkr_pkg::NREG-1:0][3:0]        current_limit_code_valley_amp_o,
  output var  logic [bkr_pkg::NREG-1:0]             vin_ov_high_o,
  // Interrupt
  output logic                                      interrupt_out_n_o
);

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] code_to_mv(input logic [7:0] code, input logic low);
    logic [7:0] c;
    c = code;
    if (low) begin
      code_to_mv = bkr_pkg::MV_BASE + 16'(c) * 16'(bkr_pkg::STEP_LO_MV);
    end else begin
      if (c > bkr_pkg::CODE_CLAMP) begin
        c = bkr_pkg::CODE_CLAMP;
      end
      code_to_mv = bkr_pkg::MV_BASE + 16'(c) * 16'(bkr_pkg::STEP_HI_MV);
    end
  endfunction : code_to_mv

  // Peak and valley thresholds in whole amps
  function automatic logic [7:0] current_limit_code_lookup(input logic [1:0] code, input logic big);
    case ({big, code})
      3'b100:  current_limit_code_lookup = {4'h6, 4'h5};
      3'b101:  current_limit_code_lookup = {4'h7, 4'h6};
      3'b110:  current_limit_code_lookup = {4'h8, 4'h7};
      3'b111:  current_limit_code_lookup = {4'h9, 4'h8};
      3'b000:  current_limit_code_lookup = {4'h4, 4'h3};
      3'b001:  current_limit_code_lookup = {4'h5, 4'h4};
      3'b010:  current_limit_code_lookup = {4'h6, 4'h6};
      3'b011:  current_limit_code_lookup = {4'h7, 4'h6};
      default: current_limit_code_lookup = {4'h4, 4'h3};
    endcase
  endfunction : current_limit_code_lookup

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [bkr_pkg::NREG-1:0][7:0] normal_setpoint_r;
  logic [bkr_pkg::NREG-1:0][7:0] scaled_setpoint_r;
  bkr_pkg::bkr_cfg_s [bkr_pkg::NREG-1:0] cfg_r;
  logic [1:0]                    mask_r;
  logic [bkr_pkg::NREG-1:0]      current_warning_flag_r;
  logic [bkr_pkg::NREG-1:0]      short_flag_r;
  logic [bkr_pkg::NREG-1:0]      walking_w;
  logic [bkr_pkg::NREG-1:0]      on_w;

  wire       perreg_sel = (reg_addr_i[7:4] == bkr_pkg::PERREG_HI);
  wire [1:0] reg_idx    = reg_addr_i[3:2];
  wire [1:0] reg_fld    = reg_addr_i[1:0];
  wire       mask_sel   = (reg_addr_i == bkr_pkg::ADDR_MASK);

  wire [7:0] status_w = {3'h0, on_w[reg_idx], walking_w[reg_idx], power_ok_status_i[reg_idx],
                         short_flag_r[reg_idx], current_warning_flag_r[reg_idx]};

  wire [7:0] perreg_rd = (reg_fld == bkr_pkg::OFS_NORMAL) ? normal_setpoint_r[reg_idx] :
                         (reg_fld == bkr_pkg::OFS_SCALED) ? scaled_setpoint_r[reg_idx] :
                         (reg_fld == bkr_pkg::OFS_CFG)    ? 8'(cfg_r[reg_idx]) : status_w;

  wire [7:0] rd_mux = perreg_sel ? perreg_rd : (mask_sel ? {6'h0, mask_r} : 8'h00);

  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_mux;
    end
  end

  // Range bit stays writable while enabled; host keeps it steady then.
  always_ff @(posedge mclk_i) begin
    if (!rst_b_i) begin
      for (int i = 0; i < bkr_pkg::NREG; i++) begin
        normal_setpoint_r[i] <= bkr_pkg::RST_NORMAL;
        scaled_setpoint_r[i] <= bkr_pkg::RST_SCALED;
        cfg_r[i]             <= bkr_pkg::RST_CFG;
      end
      mask_r <= bkr_pkg::RST_MASK;
    end else if (reg_wr_i) begin
      if (perreg_sel && reg_fld == bkr_pkg::OFS_NORMAL) begin
        normal_setpoint_r[reg_idx] <= reg_wdata_i;
      end
      if (perreg_sel && reg_fld == bkr_pkg::OFS_SCALED) begin
        scaled_setpoint_r[reg_idx] <= reg_wdata_i;
      end
      if (perreg_sel && reg_fld == bkr_pkg::OFS_CFG) begin
        cfg_r[reg_idx] <= bkr_pkg::bkr_cfg_s'(reg_wdata_i);
      end
      if (mask_sel) begin
        mask_r <= reg_wdata_i[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  wire irq_any = (|current_warning_flag_r & ~mask_r[bkr_pkg::MSK_WARN_BIT]) |
                 (|short_flag_r & ~mask_r[bkr_pkg::MSK_SHORT_BIT]);

  assign interrupt_out_n_o = ~irq_any;

  // ----------------------------------------------------------------
  // Per-regulator control
  // ----------------------------------------------------------------
  for (genvar g = 0; g < bkr_pkg::NREG; g++) begin : g_reg
    bkr_pkg::bkr_state_e      state_r;
    bkr_pkg::bkr_state_e      state_nxt;
    logic [bkr_pkg::CNT_W-1:0] tmr_r;
    logic [7:0]               active_r;
    logic [3:0]               step_r;
    logic [4:0]               warn_cnt_r;
    logic [1:0]               on_cnt_r;

    wire bkr_pkg::bkr_cfg_s cfg = cfg_r[g];
    wire scale_sel = (cfg.trig_src == bkr_pkg::TRIG_CMD   && cfg.scale_cmd) ||
                     (cfg.trig_src == bkr_pkg::TRIG_SLEEP && sleep_i) ||
                     (cfg.trig_src == bkr_pkg::TRIG_DEEP  && deep_sleep_mode_i);
    wire [7:0] target_code = scale_sel ? scaled_setpoint_r[g] : normal_setpoint_r[g];
    wire       range_low   = cfg.output_range_select;
    wire       en_req      = seq_enable_i[g] & cfg.enable;
    wire       running     = (state_r == bkr_pkg::ST_SOFT) || (state_r == bkr_pkg::ST_ON);
    wire       short_ev    = running & peak_short_i[g];
    wire       walking     = running && (active_r != target_code);
    wire [3:0] step_last   = range_low ? 4'(bkr_pkg::STEP_LO_CYC - 1) : 4'(bkr_pkg::STEP_HI_CYC - 1);
    wire [15:0] base_mv    = code_to_mv(active_r, range_low);
    wire [15:0] lpm_mv     = base_mv + base_mv / bkr_pkg::LPM_DIV;
    wire [7:0] current_limit_code_pv     = current_limit_code_lookup(cfg.current_limit_code, (g < 2));
    wire       clr_rd      = reg_rd_i && perreg_sel && reg_idx == 2'(g) && reg_fld == bkr_pkg::OFS_STATUS;
    wire       warn_ev     = running && cycle_start_i[g] && peak_warn_i[g] &&
                             (warn_cnt_r == bkr_pkg::WARN_CYCLES - 5'h01);
    wire       tmr_ss_done = (tmr_r == bkr_pkg::CNT_W'(SS_CYCLES - 1));
    wire       tmr_rt_done = (tmr_r == bkr_pkg::CNT_W'(RETRY_CYCLES - 1));
    wire       min_on_done = (on_cnt_r >= 2'(bkr_pkg::HS_MIN_CYC));

    assign walking_w[g] = walking;
    assign on_w[g]      = (state_r == bkr_pkg::ST_ON);

    always_comb begin
      state_nxt = state_r;
      case (state_r)
        bkr_pkg::ST_OFF: begin
          if (en_req) begin
            state_nxt = bkr_pkg::ST_SOFT;
          end
        end
        bkr_pkg::ST_SOFT: begin
          if (!en_req) begin
            state_nxt = bkr_pkg::ST_OFF;
          end else if (short_ev) begin
            state_nxt = bkr_pkg::ST_RETRY;
          end else if (tmr_ss_done) begin
            state_nxt = bkr_pkg::ST_ON;
          end
        end
        bkr_pkg::ST_ON: begin
          if (!en_req) begin
            state_nxt = bkr_pkg::ST_OFF;
          end else if (short_ev) begin
            state_nxt = bkr_pkg::ST_RETRY;
          end
        end
        bkr_pkg::ST_RETRY: begin
          if (!en_req) begin
            state_nxt = bkr_pkg::ST_OFF;
          end else if (tmr_rt_done) begin
            state_nxt = bkr_pkg::ST_SOFT;
          end
        end
        default: state_nxt = bkr_pkg::ST_OFF;
      endcase
    end

    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        state_r <= bkr_pkg::ST_OFF;
        tmr_r   <= '0;
      end else begin
        state_r <= state_nxt;
        tmr_r   <= (state_nxt != state_r) ? '0 : tmr_r + 1'b1;
      end
    end

    // Setpoint walk; while off the code follows the target so soft start ramps to it
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        active_r <= 8'h00;
        step_r   <= 4'h0;
      end else if (!running) begin
        active_r <= target_code;
        step_r   <= 4'h0;
      end else if (!walking) begin
        step_r <= 4'h0;
      end else if (step_r >= step_last) begin
        step_r   <= 4'h0;
        active_r <= (active_r < target_code) ? active_r + 8'h01 : active_r - 8'h01;
      end else begin
        step_r <= step_r + 4'h1;
      end
    end

    // Consecutive 75 percent cycles; the set wins over a same-cycle read
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        warn_cnt_r                <= 5'h00;
        current_warning_flag_r[g] <= 1'b0;
        short_flag_r[g]           <= 1'b0;
      end else begin
        if (!running || (cycle_start_i[g] && !peak_warn_i[g])) begin
          warn_cnt_r <= 5'h00;
        end else if (cycle_start_i[g] && warn_cnt_r < bkr_pkg::WARN_CYCLES) begin
          warn_cnt_r <= warn_cnt_r + 5'h01;
        end
        current_warning_flag_r[g] <= warn_ev | (current_warning_flag_r[g] & ~clr_rd);
        short_flag_r[g]           <= short_ev | (short_flag_r[g] & ~clr_rd);
      end
    end

    // High side: valley holds off a new pulse, peak cuts it only after the minimum on time
    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        hs_gate_o[g] <= 1'b0;
        on_cnt_r     <= 2'h0;
      end else if (!running || short_ev) begin
        hs_gate_o[g] <= 1'b0;
        on_cnt_r     <= 2'h0;
      end else if (!hs_gate_o[g]) begin
        hs_gate_o[g] <= hs_request_i[g] & ~valley_limit_i[g];
        on_cnt_r     <= 2'h1;
      end else if (min_on_done && (!hs_request_i[g] || peak_limit_i[g])) begin
        hs_gate_o[g] <= 1'b0;
        on_cnt_r     <= 2'h0;
      end else if (!min_on_done) begin
        on_cnt_r <= on_cnt_r + 2'h1;
      end
    end

    always_ff @(posedge mclk_i) begin
      if (!rst_b_i) begin
        target_mv_o[g]             <= 16'h0000;
        active_code_o[g]           <= 8'h00;
        range_low_o[g]             <= 1'b0;
        run_o[g]                   <= 1'b0;
        soft_start_o[g]            <= 1'b0;
        discharge_o[g]             <= 1'b1;
        force_pwm_o[g]             <= 1'b0;
        power_save_allow_o[g]      <= 1'b0;
        light_load_power_mode_o[g] <= 1'b0;
        ovuv_ignore_o[g]           <= 1'b0;
        current_limit_code_peak_amp_o[g]         <= 4'h0;
        current_limit_code_valley_amp_o[g]       <= 4'h0;
        vin_ov_high_o[g]           <= 1'b0;
      end else begin
        target_mv_o[g]             <= cfg.low_power_enable ? lpm_mv : base_mv;
        active_code_o[g]           <= active_r;
        range_low_o[g]             <= range_low;
        run_o[g]                   <= running;
        soft_start_o[g]            <= (state_r == bkr_pkg::ST_SOFT);
        discharge_o[g]             <= ~running;
        force_pwm_o[g]             <= walking;
        power_save_allow_o[g]      <= running & ~walking;
        light_load_power_mode_o[g] <= running & cfg.low_power_enable;
        ovuv_ignore_o[g]           <= walking;
        current_limit_code_peak_amp_o[g]         <= current_limit_code_pv[7:4];
        current_limit_code_valley_amp_o[g]       <= current_limit_code_pv[3:0];
        vin_ov_high_o[g]           <= VIN_OV_HIGH[g];
      end
    end
  end

endmodule : bkr_ctrl

`default_nettype wire

// *** core/bkr_pkg.sv ***
package bkr_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NREG  = 4;
  localparam int CNT_W = 20;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the register port)
  // ----------------------------------------------------------------
  localparam logic [1:0] OFS_NORMAL = 2'h0;
  localparam logic [1:0] OFS_SCALED = 2'h1;
  localparam logic [1:0] OFS_CFG    = 2'h2;
  localparam logic [1:0] OFS_STATUS = 2'h3;
  localparam logic [7:0] ADDR_MASK  = 8'h10;
  localparam logic [3:0] PERREG_HI  = 4'h0;

  // Status bit positions
  localparam int ST_WARN_BIT  = 0;
  localparam int ST_SHORT_BIT = 1;

  // Mask register bit positions
  localparam int MSK_WARN_BIT  = 0;
  localparam int MSK_SHORT_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_NORMAL = 8'h3c;
  localparam logic [7:0] RST_SCALED = 8'h3c;
  localparam logic [7:0] RST_CFG    = 8'h01;
  localparam logic [1:0] RST_MASK   = 2'h0;

  // Scaling trigger source
  localparam logic [1:0] TRIG_CMD   = 2'h0;
  localparam logic [1:0] TRIG_SLEEP = 2'h1;
  localparam logic [1:0] TRIG_DEEP  = 2'h2;

  // ----------------------------------------------------------------
  // Voltage mapping, millivolts
  // ----------------------------------------------------------------
  localparam logic [15:0] MV_BASE    = 16'h0258;
  localparam logic [7:0]  STEP_HI_MV = 8'h14;
  localparam logic [7:0]  STEP_LO_MV = 8'h05;
  localparam logic [7:0]  CODE_CLAMP = 8'he9;
  localparam logic [15:0] LPM_DIV    = 16'h0032;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_NS       = 25;
  localparam int SLEW_LO_MVUS = 20;
  localparam int SLEW_HI_MVUS = 80;
  localparam int STEP_LO_NS   = 5 * 1000 / SLEW_LO_MVUS;
  localparam int STEP_HI_NS   = 20 * 1000 / SLEW_HI_MVUS;
  localparam int STEP_LO_CYC  = STEP_LO_NS / CLK_NS;
  localparam int STEP_HI_CYC  = STEP_HI_NS / CLK_NS;
  localparam int SS_MS        = 1;
  localparam int SS_CYC       = SS_MS * 1000000 / CLK_NS;
  localparam int RETRY_MS     = 14;
  localparam int RETRY_CYC    = RETRY_MS * 1000000 / CLK_NS;
  localparam int HS_MIN_NS    = 50;
  localparam int HS_MIN_CYC   = (HS_MIN_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [4:0] WARN_CYCLES = 5'h10;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       scale_cmd;
    logic [1:0] trig_src;
    logic [1:0] current_limit_code;
    logic       low_power_enable;
    logic       output_range_select;
    logic       enable;
  } bkr_cfg_s;

  typedef enum logic [1:0] {
    ST_OFF   = 2'b00,
    ST_SOFT  = 2'b01,
    ST_ON    = 2'b11,
    ST_RETRY = 2'b10
  } bkr_state_e;

endpackage : bkr_pkg

// *** testbench/bkr_ctrl_properties.sv ***
`timescale 1ns/1ps
`default_nettype none

module bkr_ctrl_properties #(
  parameter int         RETRY_CYCLES = 30,
  parameter logic [3:0] VIN_OV_HIGH  = 4'h0
) (
  // Clock and reset
  input wire logic             mclk_i,
  input wire logic             rst_b_i,
  // Watched inputs
  input wire logic [3:0]       seq_enable_i,
  input wire logic [3:0]       peak_short_i,
  input wire logic [3:0]       valley_limit_i,
  // Watched outputs
  input wire logic [3:0][15:0] target_mv_o,
  input wire logic [3:0][7:0]  active_code_o,
  input wire logic [3:0]       range_low_o,
  input wire logic [3:0]       run_o,
  input wire logic [3:0]       soft_start_o,
  input wire logic [3:0]       discharge_o,
  input wire logic [3:0]       force_pwm_o,
  input wire logic [3:0]       power_save_allow_o,
  input wire logic [3:0]       light_load_power_mode_o,
  input wire logic [3:0]       ovuv_ignore_o,
  input wire logic [3:0]       hs_gate_o,
  input wire logic [3:0]       vin_ov_high_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  localparam int RWIN = RETRY_CYCLES + 5;

  // ----------------------------------------
  // Expected target, kept apart from the design
  // ----------------------------------------
  function automatic logic [15:0] exp_mv(logic [7:0] c, logic lo, logic lp);
    logic [15:0] mv;
    mv = lo ? 16'h0258 + 16'(c) * 16'h0005 : (c > 8'he9 ? 16'h148c : 16'h0258 + 16'(c) * 16'h0014);
    return lp ? mv + mv / 16'h0032 : mv;
  endfunction : exp_mv

  sequence steady;
    run_o[0] && $stable(active_code_o[0]) && $stable(range_low_o[0]) && $stable(light_load_power_mode_o[0]);
  endsequence
  sequence step_seen;
    $past(run_o[0]) && run_o[0] && $changed(active_code_o[0]);
  endsequence

  disch_off_a: assert property (discharge_o == ~run_o) else $error("discharge vs run");
  soft_hold_a: assert property ($rose(soft_start_o[0]) |-> (soft_start_o[0] && run_o[0]) [*8])
    else $error("soft start short");
  walk_flags_a: assert property (force_pwm_o[0] |-> ovuv_ignore_o[0] && !power_save_allow_o[0])
    else $error("walk flags");
  step_one_a: assert property (step_seen |-> 8'(active_code_o[0] - $past(active_code_o[0])) inside {8'h01, 8'hff})
    else $error("step not one code");
  step_gap_a: assert property (step_seen |=> $stable(active_code_o[0]) [*8]) else $error("step too soon");
  vout_map_a: assert property (steady [*3] |->
    target_mv_o[0] == exp_mv(active_code_o[0], range_low_o[0], light_load_power_mode_o[0])) else $error("target mv");
  short_stop_a: assert property (run_o[3] && peak_short_i[3] |=> !hs_gate_o[3] ##1 !run_o[3])
    else $error("short not stopped");
  short_retry_a: assert property ($fell(run_o[3]) && $past(peak_short_i[3], 2) && seq_enable_i[3] |->
    ##[1:RWIN] soft_start_o[3]) else $error("no retry");
  hs_min_a: assert property ($rose(hs_gate_o[0]) && !peak_short_i[0] && seq_enable_i[0] |=> hs_gate_o[0])
    else $error("gate too short");
  valley_hold_a: assert property (valley_limit_i[0] && !hs_gate_o[0] |=> !hs_gate_o[0])
    else $error("gate in valley");
  vin_fixed_a: assert property ($past(rst_b_i) |-> vin_ov_high_o == VIN_OV_HIGH) else $error("ov choice");
endmodule : bkr_ctrl_properties

bind bkr_ctrl bkr_ctrl_properties #(.RETRY_CYCLES(RETRY_CYCLES), .VIN_OV_HIGH(VIN_OV_HIGH)) u_props (.*);

`default_nettype wire

// *** testbench/bkr_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module bkr_host (
  // Clock and read data
  input  wire logic       mclk_i,
  input  wire logic [7:0] reg_rdata_o,
  // Register strobes
  output logic            reg_wr_i,
  output logic            reg_rd_i,
  output logic [7:0]      reg_addr_i,
  output logic [7:0]      reg_wdata_i
);
  initial {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = 18'h0;

  // ----------------------------------------
  // One access; strobe dropped only after its taking edge
  // ----------------------------------------
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge mclk_i);
    #2;
    {reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i} = {w, !w, a, d};
    @(posedge mclk_i);
    #2;
    q = reg_rdata_o;
    {reg_wr_i, reg_rd_i} = 2'h0;
  endtask : acc
endmodule : bkr_host

`default_nettype wire

// *** testbench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin error_cnt++; $display("BAD %s exp %h got %h", nm, ex, gt); end end

module tb;
  int error_cnt = 0;
  int checks_done = 0;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic sleep_i = 1'b0;
  logic deep_sleep_mode_i = 1'b0;
  logic [3:0] seq_enable_i = 4'h0, power_ok_status_i = 4'hf, cycle_start_i = 4'h0, hs_request_i = 4'h0;
  logic [3:0] peak_warn_i = 4'h0, peak_limit_i = 4'h0, peak_short_i = 4'h0, valley_limit_i = 4'h0;
  logic reg_wr_i, reg_rd_i, interrupt_out_n_o;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
  logic [3:0][15:0] target_mv_o;
  logic [3:0][7:0] active_code_o;
  logic [3:0][3:0] current_limit_code_peak_amp_o, current_limit_code_valley_amp_o;
  logic [3:0] range_low_o, run_o, soft_start_o, discharge_o, force_pwm_o, power_save_allow_o;
  logic [3:0] light_load_power_mode_o, ovuv_ignore_o, hs_gate_o, vin_ov_high_o;

  // Short counts keep soft start and retry within a brief run
  bkr_ctrl #(.SS_CYCLES(20), .RETRY_CYCLES(30), .VIN_OV_HIGH(4'h5)) DUT (.*);
  bkr_host host (.*);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.acc(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    host.acc(1'b0, a, 8'h00, q);
  endtask : rd
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_i);
    #2;
  endtask : cyc
  function automatic logic sig(input int s);
    return s < 4 ? soft_start_o[s] : force_pwm_o[0];
  endfunction : sig
  task automatic wt(input int s, input logic v, input int lim, output int n);
    for (n = 0; n < lim && sig(s) !== v; n++) cyc(1);
  endtask : wt
  task automatic settle(input logic [7:0] c);
    for (int n = 0; n < 4000 && (active_code_o[0] !== c || force_pwm_o[0] !== 1'b0); n++) cyc(1);
    cyc(3);
    `CHK("code", c, active_code_o[0])
  endtask : settle
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd(8'h00);
    `CHK("normal", 8'h3c, q)
    rd(8'h02);
    `CHK("cfg", 8'h01, q)
    rd(8'h20);
    `CHK("unmapped", 8'h00, q)
    `CHK("disch", 4'hf, discharge_o)
    `CHK("irq", 1'b1, interrupt_out_n_o)
    `CHK("ov", 4'h5, vin_ov_high_o)
  endtask : t_reset
  task automatic t_soft();
    int n;
    seq_enable_i = 4'hf;
    wt(0, 1'b1, 9, n);
    wt(0, 1'b0, 99, n);
    `CHK("soft len", 20, n)
    `CHK("run", 4'hf, run_o)
    `CHK("disch", 4'h0, discharge_o)
  endtask : t_soft
  task automatic t_map();
    settle(8'h3c);
    `CHK("hi mv", 16'h0708, target_mv_o[0])
    wr(8'h00, 8'hf0);
    settle(8'hf0);
    `CHK("clamp", 16'h148c, target_mv_o[0])
    rd(8'h00);
    `CHK("kept", 8'hf0, q)
    // Range only changes while the output is off
    wr(8'h02, 8'h00);
    wr(8'h02, 8'h02);
    wr(8'h02, 8'h07);
    cyc(25);
    settle(8'hf0);
    `CHK("lpm mv", 16'h072c, target_mv_o[0])
    `CHK("range", 4'h1, range_low_o)
    `CHK("llpm", 1'b1, light_load_power_mode_o[0])
    wr(8'h02, 8'h03);
    cyc(3);
    `CHK("lo mv", 16'h0708, target_mv_o[0])
  endtask : t_map
  task automatic t_scale();
    int n;
    logic [7:0] cfg [3] = '{8'h83, 8'h23, 8'h43};
    wr(8'h01, 8'he8);
    for (int k = 0; k < 3; k++) begin
      wr(8'h02, cfg[k]);
      {deep_sleep_mode_i, sleep_i} = k[1:0];
      wt(4, 1'b1, 9, n);
      `CHK("ovuv", 1'b1, ovuv_ignore_o[0])
      `CHK("psave", 1'b0, power_save_allow_o[0])
      wt(4, 1'b0, 200, n);
      `CHK("walk time", 1'b1, n > 70 && n < 90)
      `CHK("scaled", 8'he8, active_code_o[0])
      `CHK("psave on", 1'b1, power_save_allow_o[0])
      wr(8'h02, 8'h03);
      {deep_sleep_mode_i, sleep_i} = 2'h0;
      settle(8'hf0);
    end
  endtask : t_scale
  task automatic t_current_limit_code();
    for (int c = 0; c < 2; c++) begin
      wr(8'h02, 8'h03 | 8'(c << 3));
      wr(8'h0a, 8'h01 | 8'(c << 3));
      cyc(2);
      `CHK("pk12", 4'h6 + 4'(c), current_limit_code_peak_amp_o[0])
      `CHK("vl12", 4'h5 + 4'(c), current_limit_code_valley_amp_o[0])
      `CHK("pk34", 4'h4 + 4'(c), current_limit_code_peak_amp_o[2])
      `CHK("vl34", 4'h3 + 4'(c), current_limit_code_valley_amp_o[2])
    end
  endtask : t_current_limit_code
  task automatic t_warn();
    peak_warn_i = 4'h2;
    for (int p = 1; p <= 16; p++) begin
      cycle_start_i = 4'h2;
      cyc(1);
      cycle_start_i = 4'h0;
      cyc(1);
      if (p == 15) `CHK("no warn", 1'b1, interrupt_out_n_o)
    end
    peak_warn_i = 4'h0;
    `CHK("warn irq", 1'b0, interrupt_out_n_o)
    rd(8'h07);
    `CHK("status", 8'h15, q)
    `CHK("irq clr", 1'b1, interrupt_out_n_o)
    rd(8'h07);
    `CHK("status clr", 8'h14, q)
  endtask : t_warn
  task automatic t_short();
    int n;
    for (int m = 1; m >= 0; m--) begin
      wr(8'h10, m[0] ? 8'h02 : 8'h00);
      peak_short_i = 4'h8;
      cyc(1);
      peak_short_i = 4'h0;
      `CHK("irq", m[0], interrupt_out_n_o)
      cyc(1);
      `CHK("off", 1'b0, run_o[3])
      `CHK("disch", 1'b1, discharge_o[3])
      wt(3, 1'b1, 60, n);
      `CHK("retry", 1'b1, n > 25 && n < 33)
      rd(8'h0f);
      `CHK("latched", 1'b1, q[1])
      rd(8'h0f);
      `CHK("read clr", 1'b0, q[1])
    end
  endtask : t_short
  task automatic t_gate();
    hs_request_i = 4'h1;
    cyc(1);
    hs_request_i = 4'h0;
    `CHK("gate on", 1'b1, hs_gate_o[0])
    cyc(1);
    `CHK("gate min", 1'b1, hs_gate_o[0])
    cyc(1);
    `CHK("gate off", 1'b0, hs_gate_o[0])
    // Request held high: only the peak limit can end this pulse
    {peak_limit_i, hs_request_i} = 8'h11;
    cyc(1);
    `CHK("peak on", 1'b1, hs_gate_o[0])
    cyc(2);
    `CHK("peak cut", 1'b0, hs_gate_o[0])
    peak_limit_i = 4'h0;
    {valley_limit_i, hs_request_i} = 8'h11;
    cyc(2);
    `CHK("valley", 1'b0, hs_gate_o[0])
    {valley_limit_i, hs_request_i} = 8'h00;
    wr(8'h06, 8'h00);
    cyc(2);
    `CHK("one off", 4'hd, run_o)
    `CHK("disch one", 4'h2, discharge_o)
  endtask : t_gate

  initial forever #12.5 mclk_i = ~mclk_i;
  initial begin
    cyc(16);
    rst_b_i = 1'b1;
    t_reset();
    t_soft();
    t_map();
    t_scale();
    t_current_limit_code();
    t_warn();
    t_short();
    t_gate();
    close_out();
  end
  initial begin
    cyc(40000);
    error_cnt++;
    close_out();
  end
endmodule : tb

`default_nettype wire
